// ===== otcs_defines.svh
// constants for the oscillator trim and clock switch block
// assumes one 200 MHz system clock and a 32-bit register bus
`ifndef OTCS_DEFINES_SVH
`define OTCS_DEFINES_SVH

`define OTCS_CLK_FREQ_KHZ 200000
`define OTCS_INT_NOM_FREQ_KHZ 12800
// nominal internal period in sixteenths of a system clock cycle
`define OTCS_NOM_PER16 ((16 * `OTCS_CLK_FREQ_KHZ) / `OTCS_INT_NOM_FREQ_KHZ)
`define OTCS_PHASE_STEP 9'h010
`define OTCS_TRIM_MID 9'h080
`define OTCS_ACT_EDGES 2'h2

`define OTCS_OFF_TRIM 12'h000
`define OTCS_OFF_STATUS 12'h004
`define OTCS_OFF_CONFIG 12'h008

`define OTCS_TRIM_RST 8'h80
`define OTCS_STAT_ACTIVE_BIT 0
`define OTCS_STAT_REQ_BIT 1
`define OTCS_CFG_OPT_LSB 0
`define OTCS_CFG_OUTEN_BIT 2

`define OTCS_RESP_OKAY 2'h0
`define OTCS_RESP_SLVERR 2'h2

`endif

// ===== otcs_pkg.sv
// types for the oscillator trim and clock switch block
// assumes otcs_defines.svh holds every number
package otcs_pkg;

    typedef enum logic [1:0] {
        OTCS_OPT_INTERNAL = 2'b00,
        OTCS_OPT_EXT_CLOCK = 2'b01,
        OTCS_OPT_RC = 2'b10,
        OTCS_OPT_CRYSTAL = 2'b11
    } otcs_opt_t;

    typedef enum logic [1:0] {
        OTCS_ST_INTERNAL = 2'b00,
        OTCS_ST_CHECK = 2'b01,
        OTCS_ST_SWITCH = 2'b10,
        OTCS_ST_EXTERNAL = 2'b11
    } otcs_state_t;

endpackage : otcs_pkg

// ===== otcs_osc_if.sv
// control bundle between the switch logic and the internal oscillator model
// assumes both ends share clk
`timescale 1ns/1ps
interface otcs_osc_if;
    logic [7:0] trim;
    logic run;
    logic tick;
    modport ctl (output trim, output run, input tick);
    modport osc (input trim, input run, output tick);
endinterface : otcs_osc_if

// ===== otcs_int_osc.sv
// internal oscillator model: one tick pulse per trimmed period
// assumes clk at 200 MHz; period kept in sixteenths of a cycle
`timescale 1ns/1ps
`include "otcs_defines.svh"
module otcs_int_osc (
    input wire logic clk,
    input wire logic reset,
    otcs_osc_if.osc osc
);
    import otcs_pkg::*;

    logic [8:0] acc_r;
    logic [8:0] acc_nxt;
    logic tick_r;
    wire [8:0] period = 9'(`OTCS_NOM_PER16) + {1'b0, osc.trim} - `OTCS_TRIM_MID;
    wire [8:0] acc_step = acc_r + `OTCS_PHASE_STEP;
    wire wrap = acc_step >= period;

    assign acc_nxt = !osc.run ? 9'h000 : (wrap ? acc_step - period : acc_step);
    // masked at once when run drops, so no stale tick follows the stop
    assign osc.tick = tick_r & osc.run;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            acc_r <= 9'h000;
            tick_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            tick_r <= osc.run & wrap;
        end
    end
endmodule : otcs_int_osc

// ===== otcs_rise_detect.sv
// rising edge detector for the external clock pin
// assumes the pin is already synchronous to clk
`timescale 1ns/1ps
module otcs_rise_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    input wire logic enable,
    output logic rise,
    output logic level
);
    logic last_r;
    logic rise_r;

    assign rise = rise_r;
    assign level = last_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            last_r <= 1'b0;
            rise_r <= 1'b0;
        end
        else
        begin
            last_r <= pin;
            rise_r <= enable & pin & ~last_r;
        end
    end
endmodule : otcs_rise_detect

// ===== otcs_top.sv
// oscillator trim register and internal-to-external clock handover
// assumes an AXI4-Lite master; bus clocks leave as one-cycle enable pulses
//
// Contract
// - an 8-bit writable trim sets the internal period; larger means longer.
// - trim acts as signed offset, -128 to +127 steps about nominal.
// - trim range reaches 12.8 MHz nominal within five percent.
// - factory trim is never loaded into the trim register by hardware.
// - external option makes input pin a clock; crystal also drives output pin.
// - after the request, two external rising edges confirm activity.
// - the derived clocks change source with no glitch or runt pulse.
// - the active bit is set first, then the internal oscillator stops.
// - once external, the internal oscillator stays off until reset.
// - no clock-loss monitor and no fallback to the internal oscillator.
// - external mode uses input clock as x4 and half of it as x2.
// - external mode keeps the clock-output enable cleared; pin is port I/O, except that the crystal option drives it.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "otcs_defines.svh"
module otcs_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clock_in_pin,
    output logic clock_in_pin_is_clock,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe_n,
    output logic clock_out_pin_enable,
    output otcs_pkg::otcs_opt_t clock_source_option,
    output logic bus_clock_times_four,
    output logic bus_clock_times_two,
    output logic int_osc_running
);
    import otcs_pkg::*;
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
        addr_hit = addr[11:2] == off[11:2];
    endfunction : addr_hit
    otcs_osc_if osc_bus ();
    // register state
    logic [7:0] trim_r;
    logic req_r;
    logic ext_active_r;
    otcs_opt_t opt_r;
    logic outen_cfg_r;
    otcs_state_t state_r;
    otcs_state_t state_nxt;
    logic [1:0] edge_cnt_r;
    logic int_run_r;
    // bus slave state
    logic awready_r;
    logic wready_r;
    logic have_aw_r;
    logic have_w_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    // pin and clock outputs
    logic is_clock_r;
    logic out_o_r;
    logic out_oe_n_r;
    logic out_en_r;
    logic x4_r;
    logic x2_r;
    logic half_r;
    // write channel decode
    wire aw_take = s_axi_awvalid & awready_r;
    wire w_take = s_axi_wvalid & wready_r;
    wire do_write = have_aw_r & have_w_r & ~bvalid_r;
    wire have_aw_nxt = (have_aw_r | aw_take) & ~do_write;
    wire have_w_nxt = (have_w_r | w_take) & ~do_write;
    wire bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
    wire wr_trim = do_write & addr_hit(awaddr_r, `OTCS_OFF_TRIM) & wstrb_r[0];
    wire wr_stat = do_write & addr_hit(awaddr_r, `OTCS_OFF_STATUS) & wstrb_r[0];
    wire wr_cfg = do_write & addr_hit(awaddr_r, `OTCS_OFF_CONFIG) & wstrb_r[0];
    wire wr_mapped = addr_hit(awaddr_r, `OTCS_OFF_TRIM) |
        addr_hit(awaddr_r, `OTCS_OFF_STATUS) | addr_hit(awaddr_r, `OTCS_OFF_CONFIG);
    wire set_req = wr_stat & wdata_r[`OTCS_STAT_REQ_BIT];
    // option is frozen once the handover starts so the pins cannot move under it
    wire cfg_open = state_r == OTCS_ST_INTERNAL & ~req_r;
    // read channel decode
    wire ar_take = s_axi_arvalid & arready_r;
    wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
    wire rd_trim = addr_hit(s_axi_araddr, `OTCS_OFF_TRIM);
    wire rd_stat = addr_hit(s_axi_araddr, `OTCS_OFF_STATUS);
    wire rd_cfg = addr_hit(s_axi_araddr, `OTCS_OFF_CONFIG);
    wire [31:0] stat_word = {30'h0000_0000, req_r, ext_active_r};
    wire [31:0] cfg_word = {29'h0000_0000, outen_cfg_r, opt_r};
    wire [31:0] rd_word = rd_trim ? {24'h00_0000, trim_r} :
        rd_stat ? stat_word : rd_cfg ? cfg_word : 32'h0000_0000;
    wire rd_mapped = rd_trim | rd_stat | rd_cfg;
    // external clock pin
    wire ext_sel = opt_r != OTCS_OPT_INTERNAL;
    wire ext_rise;
    wire ext_level;
    otcs_rise_detect u_rise (
        .clk(clk),
        .reset(reset),
        .pin(clock_in_pin),
        .enable(ext_sel),
        .rise(ext_rise),
        .level(ext_level)
    );
    assign osc_bus.trim = trim_r;
    assign osc_bus.run = int_run_r;
    otcs_int_osc u_osc (
        .clk(clk),
        .reset(reset),
        .osc(osc_bus)
    );

    wire x4_nxt = ext_active_r ? ext_rise : osc_bus.tick;
    wire x2_nxt = x4_nxt & half_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            OTCS_ST_INTERNAL:
                if (req_r)
                    state_nxt = OTCS_ST_CHECK;
            OTCS_ST_CHECK:
                if (ext_rise && edge_cnt_r == `OTCS_ACT_EDGES - 2'h1)
                    state_nxt = OTCS_ST_SWITCH;
            OTCS_ST_SWITCH:
                state_nxt = OTCS_ST_EXTERNAL;
            OTCS_ST_EXTERNAL:
                state_nxt = OTCS_ST_EXTERNAL;
            default:
                state_nxt = OTCS_ST_INTERNAL;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= OTCS_ST_INTERNAL;
            edge_cnt_r <= 2'h0;
            req_r <= 1'b0;
            ext_active_r <= 1'b0;
            int_run_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == OTCS_ST_CHECK && ext_rise)
                edge_cnt_r <= edge_cnt_r + 2'h1;
            if (set_req)
                req_r <= 1'b1;
            if (state_r == OTCS_ST_SWITCH)
                ext_active_r <= 1'b1;
            if (state_r == OTCS_ST_EXTERNAL)
                int_run_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            trim_r <= `OTCS_TRIM_RST;
            opt_r <= OTCS_OPT_INTERNAL;
            outen_cfg_r <= 1'b0;
        end
        else
        begin
            if (wr_trim)
                trim_r <= wdata_r[7:0];
            if (wr_cfg && cfg_open)
                opt_r <= otcs_opt_t'(wdata_r[`OTCS_CFG_OPT_LSB +: 2]);
            if (wr_cfg)
                outen_cfg_r <= wdata_r[`OTCS_CFG_OUTEN_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            x4_r <= 1'b0;
            x2_r <= 1'b0;
            half_r <= 1'b0;
        end
        else
        begin
            x4_r <= x4_nxt;
            x2_r <= x2_nxt;
            if (x4_nxt)
                half_r <= ~half_r;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            is_clock_r <= 1'b0;
            out_o_r <= 1'b0;
            out_oe_n_r <= 1'b1;
            out_en_r <= 1'b0;
        end
        else
        begin
            is_clock_r <= ext_sel;
            out_o_r <= opt_r == OTCS_OPT_CRYSTAL ? ~ext_level : half_r;
            out_oe_n_r <= ~(opt_r == OTCS_OPT_CRYSTAL | out_en_r);
            out_en_r <= outen_cfg_r & ~ext_active_r & ~ext_sel;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `OTCS_RESP_OKAY;
        end
        else
        begin
            awready_r <= ~have_aw_nxt;
            wready_r <= ~have_w_nxt;
            have_aw_r <= have_aw_nxt;
            have_w_r <= have_w_nxt;
            if (aw_take)
                awaddr_r <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            bvalid_r <= bvalid_nxt;
            if (do_write)
                bresp_r <= wr_mapped ? `OTCS_RESP_OKAY : `OTCS_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `OTCS_RESP_OKAY;
        end
        else
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= rd_word;
                rresp_r <= rd_mapped ? `OTCS_RESP_OKAY : `OTCS_RESP_SLVERR;
            end
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign clock_in_pin_is_clock = is_clock_r;
    assign clock_out_pin_o = out_o_r;
    assign clock_out_pin_oe_n = out_oe_n_r;
    assign clock_out_pin_enable = out_en_r;
    assign clock_source_option = opt_r;
    assign bus_clock_times_four = x4_r;
    assign bus_clock_times_two = x2_r;
    assign int_osc_running = int_run_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_trim_write;
        wr_trim |=> trim_r == $past(wdata_r[7:0]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim not stored");
    property p_trim_hold;
        !wr_trim |=> $stable(trim_r);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim moved by itself");
    property p_two_edges;
        $rose(ext_active_r) |-> $past(edge_cnt_r, 2) == `OTCS_ACT_EDGES - 2'h1;
    endproperty
    a_two_edges: assert property (p_two_edges) else $error("switch without two edges");
    property p_active_then_stop;
        $rose(ext_active_r) |-> int_run_r ##1 !int_run_r;
    endproperty
    a_active_then_stop: assert property (p_active_then_stop) else $error("stop order wrong");
    property p_osc_stays_off;
        ext_active_r && $past(ext_active_r) |-> !int_run_r && !osc_bus.tick;
    endproperty
    a_osc_stays_off: assert property (p_osc_stays_off) else $error("internal osc alive");
    property p_no_fallback;
        ext_active_r |=> ext_active_r [*8];
    endproperty
    a_no_fallback: assert property (p_no_fallback) else $error("fell back");
    property p_x4_follows_pin;
        ext_active_r && ext_rise |=> bus_clock_times_four;
    endproperty
    a_x4_follows_pin: assert property (p_x4_follows_pin) else $error("x4 missed edge");
    property p_x2_inside_x4;
        bus_clock_times_two |-> bus_clock_times_four ##1 !bus_clock_times_two;
    endproperty
    a_x2_inside_x4: assert property (p_x2_inside_x4) else $error("x2 runt");
    property p_outen_clear;
        ext_active_r |=> !clock_out_pin_enable;
    endproperty
    a_outen_clear: assert property (p_outen_clear) else $error("clock out enabled");
    property p_crystal_pin;
        opt_r == OTCS_OPT_CRYSTAL |=> !clock_out_pin_oe_n && clock_in_pin_is_clock;
    endproperty
    a_crystal_pin: assert property (p_crystal_pin) else $error("crystal pins wrong");
    c_switch_done: cover property ($rose(ext_active_r));
    c_trim_write: cover property (wr_trim);
    c_bad_addr: cover property (do_write && !wr_mapped);
endmodule : otcs_top

// ===== otcs_ext_src.sv
// external clock source model driving the clock input pin
// assumes the bench starts it only once an external option is chosen
`timescale 1ns/1ps
module otcs_ext_src #(
    parameter int HALF_NS = 20
) (
    input wire logic run,
    input wire logic slow,
    output logic pin
);
    // source is stable from its first edge, so its settling wait is zero
    // pin stands low while stopped; a 1 ns start offset keeps edges off the clk grid
    always
    begin
        if (run)
        begin
            #(slow ? 3 * HALF_NS : HALF_NS);
            pin = run ? ~pin : 1'b0;
        end
        else
        begin
            pin = 1'b0;
            @(run);
            #1;
        end
    end
endmodule : otcs_ext_src

// ===== otcs_top_bench.sv
// self-checking bench for the trim register and the clock handover
// assumes otcs_top on AXI4-Lite and otcs_ext_src on the clock input pin
`timescale 1ns/1ps
`include "otcs_defines.svh"
module otcs_top_bench;
    import otcs_pkg::*;
    // arbitrary stand-in for the stored factory byte
    localparam logic [7:0] FACTORY_TRIM = 8'h6a;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic src_run = 1'b0;
    logic src_slow = 1'b0;
    logic pin, awready, wready, bvalid, arready, rvalid;
    logic is_clock, out_o, oe_n, out_en, x4, x2, osc_run;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [1:0] rsp;
    otcs_opt_t opt;
    int n_errors = 0;
    int compares = 0;

    always #2.5 clk = ~clk;

    otcs_top i_dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clock_in_pin(pin), .clock_in_pin_is_clock(is_clock), .clock_out_pin_o(out_o),
        .clock_out_pin_oe_n(oe_n), .clock_out_pin_enable(out_en),
        .clock_source_option(opt), .bus_clock_times_four(x4), .bus_clock_times_two(x2),
        .int_osc_running(osc_run));

    otcs_ext_src i_src (.run(src_run), .slow(src_slow), .pin(pin));

    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic near(input int got, input int exp, input int tol, input string what);
        chk(32'(got <= exp + tol && got >= exp - tol), 32'h0000_0001, what);
    endtask : near

    task automatic hang(input string what);
        n_errors++;
        $display("[ERR] %0t timeout %s", $time, what);
        report_and_stop();
    endtask : hang

    // an edge passes first so no strobe is assigned twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (64)
        begin
            @(posedge clk);
            if (!aw_ok && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang("write");
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (64)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hang("read");
    endtask : rd

    task automatic wok(input logic [11:0] a, input logic [31:0] v);
        wr(a, v, rsp);
        chk(32'(rsp), 32'(`OTCS_RESP_OKAY), "write response");
    endtask : wok

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a, d, rsp);
        chk(d, exp, "read data");
        chk(32'(rsp), 32'(`OTCS_RESP_OKAY), "read response");
    endtask : rchk

    task automatic count(input int cyc, output int c4, output int c2, output int cp);
        logic pp;
        c4 = 0;
        c2 = 0;
        cp = 0;
        pp = pin;
        repeat (cyc)
        begin
            @(posedge clk);
            c4 += int'(x4 === 1'b1);
            c2 += int'(x2 === 1'b1);
            cp += int'(pin && !pp);
            pp = pin;
        end
    endtask : count

    task automatic do_reset;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic t_reset;
        rchk(`OTCS_OFF_TRIM, 32'h0000_0080);
        rchk(`OTCS_OFF_STATUS, 32'h0000_0000);
        rchk(`OTCS_OFF_CONFIG, 32'h0000_0000);
        chk(32'(osc_run), 32'h0000_0001, "internal running");
        $display("test reset done");
    endtask : t_reset

    // period grows with trim: 16 ticks take 122 + trim cycles
    task automatic t_trim;
        int c4, c2, cp;
        int tv[3] = '{0, 128, 255};
        foreach (tv[i])
        begin
            wok(`OTCS_OFF_TRIM, 32'(tv[i]));
            rchk(`OTCS_OFF_TRIM, 32'(tv[i]));
            repeat (50) @(posedge clk);
            count(1000, c4, c2, cp);
            near(c4, 16000 / (122 + tv[i]), 2, "internal tick count");
        end
        wok(`OTCS_OFF_TRIM, 32'(FACTORY_TRIM));
        rchk(`OTCS_OFF_TRIM, 32'(FACTORY_TRIM));
        $display("test trim done");
    endtask : t_trim

    task automatic t_unmapped;
        wr(12'h00c, 32'h0000_00ff, rsp);
        chk(32'(rsp), 32'(`OTCS_RESP_SLVERR), "unmapped write");
        rd(12'h00c, d, rsp);
        chk(32'(rsp), 32'(`OTCS_RESP_SLVERR), "unmapped read");
        chk(d, 32'h0000_0000, "unmapped data");
        wok(`OTCS_OFF_STATUS, 32'h0000_0001);
        rchk(`OTCS_OFF_STATUS, 32'h0000_0000);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic t_options;
        for (int o = 1; o < 4; o++)
        begin
            // precharge skipped: it is optional and the port drive lies outside
            wok(`OTCS_OFF_CONFIG, 32'(o) | 32'h0000_0004);
            repeat (2) @(posedge clk);
            chk(32'(opt), 32'(o), "option");
            chk(32'(is_clock), 32'h0000_0001, "input pin is clock");
            chk(32'(oe_n), 32'(o != 3), "output pin drive");
            chk(32'(out_en), 32'h0000_0000, "clock out enable");
            if (o == 3)
                chk(32'(out_o), 32'h0000_0001, "crystal drive of idle input");
        end
        // only the internal mode lets the clock-out enable take effect
        wok(`OTCS_OFF_CONFIG, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(32'(is_clock), 32'h0000_0000, "input pin released");
        chk(32'(out_en), 32'h0000_0001, "clock out enable internal");
        chk(32'(oe_n), 32'h0000_0000, "clock out drives pin");
        $display("test options done");
    endtask : t_options

    task automatic t_handover;
        int rises, at_stop, last, bad, c4, c2, cp;
        logic pp;
        rises = 0;
        at_stop = -1;
        last = -100;
        bad = 0;
        wok(`OTCS_OFF_CONFIG, 32'h0000_0005);
        wok(`OTCS_OFF_STATUS, 32'h0000_0002);
        // no external edges yet, so the handover must wait
        repeat (40) @(posedge clk);
        chk(32'(osc_run), 32'h0000_0001, "held without edges");
        rchk(`OTCS_OFF_STATUS, 32'h0000_0002);
        wok(`OTCS_OFF_CONFIG, 32'h0000_0000);
        rd(`OTCS_OFF_CONFIG, d, rsp);
        chk(d & 32'h0000_0003, 32'h0000_0001, "option locked");
        pp = pin;
        src_run <= 1'b1;
        for (int n = 0; n < 300; n++)
        begin
            @(posedge clk);
            rises += int'(pin && !pp);
            pp = pin;
            if (x4 === 1'b1)
            begin
                bad += int'(n - last < 7);
                last = n;
            end
            if (!osc_run && at_stop < 0)
                at_stop = rises;
        end
        if (at_stop < 0)
            hang("switch");
        chk(32'(at_stop >= 2), 32'h0000_0001, "two edges first");
        chk(32'(bad), 32'h0000_0000, "runt pulses");
        rchk(`OTCS_OFF_STATUS, 32'h0000_0003);
        for (int s = 0; s < 2; s++)
        begin
            src_slow <= 1'(s);
            repeat (30) @(posedge clk);
            count(600, c4, c2, cp);
            near(c4, cp, 1, "x4 follows input");
            near(c2, c4 / 2, 1, "x2 is half");
            chk(32'(osc_run), 32'h0000_0000, "internal stays off");
            chk(32'(out_en), 32'h0000_0000, "no clock out");
            chk(32'(oe_n), 32'h0000_0001, "pin left to port");
        end
        src_run <= 1'b0;
        repeat (20) @(posedge clk);
        count(200, c4, c2, cp);
        chk(32'(c4), 32'h0000_0000, "no fallback clock");
        chk(32'(osc_run), 32'h0000_0000, "no restart");
        rchk(`OTCS_OFF_STATUS, 32'h0000_0003);
        do_reset();
        rchk(`OTCS_OFF_STATUS, 32'h0000_0000);
        chk(32'(osc_run), 32'h0000_0001, "restart by reset");
        $display("test handover done");
    endtask : t_handover

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_trim();
        t_unmapped();
        t_options();
        t_handover();
        report_and_stop();
    end
endmodule : otcs_top_bench
